/* hdl/ndc_pkg.sv */
package ndc_pkg;
   // ----------------------------------------
   // Timing figures, fastest grade
   // ----------------------------------------
   localparam int T_CLK_NS = 10;
   localparam int T_RAH_NS = 10;
   localparam int T_RCD_NS = 15;
   localparam int T_RAC_NS = 85;
   localparam int T_RASL_NS = 85;
   localparam int T_RP_NS = 65;
   localparam int T_CR_NS = 160;
   localparam int T_CRMW_NS = 195;
   localparam int T_RWL_NS = 30;
   localparam int T_RWD_NS = 70;
   localparam int T_NC_NS = 45;
   localparam int T_NP_NS = 15;
   localparam int T_CSR_NS = 10;
   localparam int T_REF_MS = 4;
   localparam int REF_ROWS = 256;
   localparam int T_PWR_US = 500;

   function automatic int cyc_min(int ns);
      return (ns + T_CLK_NS - 1) / T_CLK_NS;
   endfunction

   function automatic int cyc_max(int ns);
      return (ns / T_CLK_NS < 1) ? 1 : ns / T_CLK_NS;
   endfunction

   // ----------------------------------------
   // Cycle counts
   // ----------------------------------------
   localparam logic [5:0] C_RAH = 6'(cyc_min(T_RAH_NS));
   localparam logic [5:0] C_RCD = 6'(cyc_min(T_RCD_NS));
   localparam logic [5:0] T_SAMP = 6'(cyc_min(T_RAC_NS) - 1);
   localparam logic [5:0] C_RASL = 6'(cyc_min(T_RASL_NS));
   localparam logic [5:0] C_CR = 6'(cyc_min(T_CR_NS));
   localparam logic [5:0] C_CRMW = 6'(cyc_min(T_CRMW_NS));
   localparam logic [5:0] C_RWL = 6'(cyc_min(T_RWL_NS));
   localparam logic [5:0] C_RWD = 6'(cyc_min(T_RWD_NS));
   localparam logic [5:0] C_CSR = 6'(cyc_min(T_CSR_NS));
   localparam logic [2:0] C_RP = 3'(cyc_min(T_RP_NS));
   localparam logic [2:0] C_NC = 3'(cyc_min(T_NC_NS));
   localparam logic [2:0] C_NP = 3'(cyc_min(T_NP_NS));
   localparam logic [15:0] C_REFI =
      16'(cyc_max(T_REF_MS * 1000000 / REF_ROWS));
   localparam logic [15:0] C_PWR_CYC = 16'(T_PWR_US * 1000 / T_CLK_NS);
   localparam logic [3:0] C_INIT_CYC = 4'h8;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_RMW, OP_NIBBLE} ndc_op_t;
   typedef enum {ST_PWR, ST_IDLE, ST_ACC, ST_NIB, ST_CBR, ST_PRE} ndc_state_t;

   typedef struct packed {
      ndc_op_t op;
      logic [8:0] row;
      logic [8:0] col;
      logic wdata;
   } ndc_req_t;

   typedef struct packed {
      logic valid;
      logic [3:0] data;
   } ndc_resp_t;

   typedef struct packed {
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [8:0] addr;
      logic d;
   } ndc_pins_t;

   localparam ndc_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 9'h000, 1'b0};
endpackage

/* hdl/ndc_ctrl.sv */
`timescale 1ns/1ps
// Summary of operation
// - Keep store strobe high after row strobe rises at end of reads.
// - Read-modify-write cycle lasts at least its minimum cycle time.
// - Nibble column cycles keep minimum period, low and high widths.
// - Nibble read-modify-write widths; this controller never issues it.
// - Refresh: column strobe low before row strobe falls and held after.
// - Eight column-before-row refreshes precede reliance on that refresh.
// - Row-only refresh needs column high; not used by this controller.
// - All rows refreshed every interval by periodic refresh cycles.
// - Power-up pause then eight refresh cycles before normal accesses.
module ndc_ctrl #(
   parameter logic [15:0] PWR_CYC = ndc_pkg::C_PWR_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input ndc_pkg::ndc_req_t req,
   input wire logic req_valid,
   output logic req_ready,
   output ndc_pkg::ndc_resp_t resp,
   output ndc_pkg::ndc_pins_t pins,
   input wire logic q
);
   import ndc_pkg::*;

   ndc_state_t st;
   ndc_op_t op;
   logic [5:0] tcnt;
   logic [2:0] ncnt;
   logic [1:0] nb;
   logic [8:0] col;
   logic [3:0] rdata;
   logic [15:0] tmr;
   logic pwr_done;
   logic ref_pend;
   logic init_done;
   logic [3:0] init_cnt;
   logic accept;
   logic ref_tick;
   logic cbr_start;
   logic [5:0] cyc_end;

   assign accept = req_valid && req_ready;
   assign ref_tick = pwr_done && (tmr == C_REFI - 16'h1);
   assign cbr_start = (st == ST_IDLE) && !accept && pwr_done &&
                      (!init_done || ref_pend);
   assign cyc_end = (op == OP_RMW) ? C_CRMW - 6'h1 : C_CR - 6'h1;

   // ----------------------------------------
   // Power-up pause and refresh interval
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tmr <= 16'h0;
         pwr_done <= 1'b0;
      end else if (ce) begin
         if (!pwr_done) begin
            if (tmr == PWR_CYC - 16'h1) begin
               pwr_done <= 1'b1;
               tmr <= 16'h0;
            end else begin
               tmr <= tmr + 16'h1;
            end
         end else if (ref_tick) begin
            tmr <= 16'h0;
         end else begin
            tmr <= tmr + 16'h1;
         end
      end
   end

   // Tick wins over the clear so no interval is lost
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ref_pend <= 1'b0;
      end else if (ce) begin
         if (ref_tick) begin
            ref_pend <= 1'b1;
         end else if (cbr_start) begin
            ref_pend <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         init_cnt <= 4'h0;
         init_done <= 1'b0;
      end else if (ce && cbr_start && !init_done) begin
         init_cnt <= init_cnt + 4'h1;
         init_done <= (init_cnt == C_INIT_CYC - 4'h1);
      end
   end

   // ----------------------------------------
   // Strobe sequencer
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= ST_PWR;
         op <= OP_READ;
         tcnt <= 6'h0;
         ncnt <= 3'h0;
         nb <= 2'h0;
         col <= 9'h000;
         rdata <= 4'h0;
         pins <= PINS_IDLE;
         resp <= '0;
         req_ready <= 1'b0;
      end else if (ce) begin
         resp.valid <= 1'b0;
         req_ready <= 1'b0;
         tcnt <= tcnt + 6'h1;
         case (st)
            ST_PWR: begin
               if (pwr_done) begin
                  st <= ST_IDLE;
               end
            end
            ST_IDLE: begin
               tcnt <= 6'h0;
               req_ready <= init_done && !ref_pend && !accept && !cbr_start;
               if (accept) begin
                  op <= req.op;
                  col <= req.col;
                  pins.ras_n <= 1'b0;
                  pins.addr <= req.row;
                  pins.we_n <= (req.op != OP_WRITE);
                  pins.d <= req.wdata;
                  nb <= 2'h0;
                  st <= ST_ACC;
               end else if (cbr_start) begin
                  pins.cas_n <= 1'b0;
                  pins.we_n <= 1'b1;
                  pins.d <= 1'b0;
                  st <= ST_CBR;
               end
            end
            ST_ACC: begin
               if (tcnt == C_RAH - 6'h1) begin
                  pins.addr <= col;
               end
               if (tcnt == C_RCD - 6'h1) begin
                  pins.cas_n <= 1'b0;
               end
               if (tcnt == T_SAMP) begin
                  rdata[0] <= q;
                  case (op)
                     OP_RMW: begin
                        pins.we_n <= 1'b0;
                     end
                     OP_NIBBLE: begin
                        pins.cas_n <= 1'b1;
                        ncnt <= 3'h0;
                        nb <= 2'h1;
                        st <= ST_NIB;
                     end
                     default: begin
                        pins.ras_n <= 1'b1;
                        pins.cas_n <= 1'b1;
                        pins.we_n <= 1'b1;
                        ncnt <= 3'h0;
                        resp.valid <= (op == OP_READ);
                        resp.data <= {3'h0, q};
                        st <= ST_PRE;
                     end
                  endcase
               end
               // Output may no longer be read data here; write fell at the sample point
               if (op == OP_RMW && tcnt == T_SAMP + C_RWL) begin
                  pins.ras_n <= 1'b1;
                  pins.cas_n <= 1'b1;
                  pins.we_n <= 1'b1;
                  ncnt <= 3'h0;
                  resp.valid <= 1'b1;
                  resp.data <= {3'h0, rdata[0]};
                  st <= ST_PRE;
               end
            end
            ST_NIB: begin
               ncnt <= ncnt + 3'h1;
               if (ncnt == C_NP - 3'h1) begin
                  pins.cas_n <= 1'b0;
               end
               if (ncnt == C_NC - 3'h1) begin
                  rdata[nb] <= q;
                  ncnt <= 3'h0;
                  if (nb == 2'h3) begin
                     pins.ras_n <= 1'b1;
                     pins.cas_n <= 1'b1;
                     resp.valid <= 1'b1;
                     resp.data <= {q, rdata[2:0]};
                     st <= ST_PRE;
                  end else begin
                     pins.cas_n <= 1'b1;
                     nb <= nb + 2'h1;
                  end
               end
            end
            ST_CBR: begin
               if (tcnt == C_CSR - 6'h1) begin
                  pins.ras_n <= 1'b0;
               end
               if (tcnt == C_CSR + C_RASL - 6'h1) begin
                  pins.ras_n <= 1'b1;
                  pins.cas_n <= 1'b1;
                  ncnt <= 3'h0;
                  st <= ST_PRE;
               end
            end
            ST_PRE: begin
               ncnt <= ncnt + 3'h1;
               if (ncnt >= C_RP - 3'h1 && tcnt >= cyc_end) begin
                  st <= ST_IDLE;
               end
            end
            default: begin
               st <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Checking
   // ----------------------------------------
   logic prev_ras;
   logic ras_fell;
   logic last_rmw;
   logic [5:0] since_fall;
   logic [15:0] since_ref;

   assign ras_fell = prev_ras && !pins.ras_n;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prev_ras <= 1'b1;
         last_rmw <= 1'b0;
         since_fall <= 6'h3f;
         since_ref <= 16'h0;
      end else if (ce) begin
         prev_ras <= pins.ras_n;
         if (ras_fell) begin
            since_fall <= 6'h0;
            last_rmw <= (st == ST_ACC) && (op == OP_RMW);
         end else if (since_fall != 6'h3f) begin
            since_fall <= since_fall + 6'h1;
         end
         if (cbr_start || !init_done) begin
            since_ref <= 16'h0;
         end else begin
            since_ref <= since_ref + 16'h1;
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n || !ce);

   a_read_hold: assert property (
      $rose(pins.ras_n) && $past(pins.we_n) |-> pins.we_n)
      else $error("store strobe fell right after read");
   a_cycle_time: assert property (
      ras_fell |-> since_fall >= (last_rmw ? C_CRMW - 6'h1 : C_CR - 6'h1))
      else $error("row cycle shorter than minimum");
   a_early_write: assert property (
      $fell(pins.cas_n) && !pins.ras_n && op == OP_WRITE |-> !pins.we_n)
      else $error("write not early at column strobe");
   a_rmw_delay: assert property (
      $fell(pins.we_n) && !pins.cas_n |-> since_fall >= C_RWD)
      else $error("read-write strobe too soon");
   a_cbr_setup: assert property (
      ras_fell && !pins.cas_n |-> $past(pins.cas_n) == 1'b0)
      else $error("column strobe not ahead of row strobe");
   a_cbr_hold: assert property (
      ras_fell && !pins.cas_n |-> (!pins.cas_n)[*3])
      else $error("column strobe hold too short");
   a_nib_precharge: assert property (
      $rose(pins.cas_n) && !pins.ras_n |-> pins.cas_n[*2])
      else $error("nibble column high too short");
   a_ras_to_cas: assert property (
      $fell(pins.cas_n) && !pins.ras_n |-> $past(pins.ras_n, 2) == 1'b0)
      else $error("row to column delay too short");
   a_refresh_gap: assert property (
      since_ref <= C_REFI + 16'h40)
      else $error("refresh interval exceeded");
   a_init_first: assert property (
      accept |-> init_done && init_cnt == C_INIT_CYC)
      else $error("access before initial refreshes");

   c_read: cover property (resp.valid && op == OP_READ);
   c_rmw: cover property (resp.valid && op == OP_RMW);
   c_nibble: cover property (resp.valid && op == OP_NIBBLE);
   c_refresh: cover property (st == ST_CBR && ras_fell);
endmodule

/* dv/ndc_dram_model.sv */
`timescale 1ns/1ps
module ndc_dram_model (
   input ndc_pkg::ndc_pins_t pins,
   output logic q,
   output int viol
);
   import ndc_pkg::*;
   // ----------------------------------------
   // Cell array and strobe history
   // ----------------------------------------
   bit mem [0:262143];
   logic [8:0] row;
   logic [8:0] col;
   logic [1:0] nib;
   logic first = 1'b0;
   logic cbr = 1'b0;
   logic rmw = 1'b0;
   realtime t_ras = 0.0;
   realtime t_cas = 0.0;
   realtime t_up = -1000.0;
   int refs = 0;
   initial begin
      q = 1'b0;
      viol = 0;
   end

   function automatic logic [17:0] key();
      return {nib[1], row[7:0], nib[0], col[7:0]};
   endfunction

   // ----------------------------------------
   // Row strobe: refresh or row latch
   // ----------------------------------------
   always @(negedge pins.ras_n) begin
      if (rmw && $realtime - t_ras < 195.0) viol++;
      rmw = 1'b0;
      t_ras = $realtime;
      cbr = !pins.cas_n;
      if (cbr) begin
         refs++;
         if (t_ras - t_cas < 10.0) viol++;
      end else begin
         if (refs < 8) viol++;
         row = pins.addr;
         first = 1'b1;
      end
   end

   // ----------------------------------------
   // Column strobe: access, write, nibble step
   // ----------------------------------------
   always @(negedge pins.cas_n) begin
      realtime dly;
      t_cas = $realtime;
      if (!pins.ras_n && !cbr) begin
         if (first) begin
            col = pins.addr;
            nib = {row[8], col[8]};
            dly = t_ras + 85.0 - t_cas;
            if (dly < 45.0) dly = 45.0;
         end else begin
            nib = nib + 2'h1;
            dly = 20.0;
            if (t_cas - t_up < 15.0) viol++;
         end
         first = 1'b0;
         if (!pins.we_n) begin
            mem[key()] = pins.d;
         end else begin
            #(dly);
            // Late sampling is harmless; early sampling sees junk
            if (!pins.cas_n) q = mem[key()];
         end
      end
   end

   always @(negedge pins.we_n) begin
      if (!pins.ras_n && !pins.cas_n && !cbr) begin
         if ($realtime - t_cas < 30.0 || $realtime - t_ras < 70.0) begin
            q = ~q;
         end
         mem[key()] = pins.d;
         rmw = 1'b1;
      end
   end

   // Released output never holds its last bit
   always @(posedge pins.cas_n) begin
      t_up = $realtime;
      q = ~q;
      if (cbr && t_up - t_ras < 15.0) viol++;
   end
endmodule

/* dv/tb_nibble_dram_cycle_rules.sv */
`timescale 1ns/1ps
module tb_nibble_dram_cycle_rules;
   import ndc_pkg::*;
   logic clk;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   ndc_req_t req = '0;
   logic req_valid = 1'b0;
   logic req_ready;
   ndc_resp_t resp;
   ndc_pins_t pins;
   logic q;
   int viol;
   int err_total = 0;
   int checks_done = 0;
   int cyc = 0;
   int refs_seen = 0;

   ndc_ctrl #(.PWR_CYC(16'h0014)) dut_u (.clk(clk), .rst_n(rst_n), .ce(ce),
      .req(req), .req_valid(req_valid), .req_ready(req_ready),
      .resp(resp), .pins(pins), .q(q));
   ndc_dram_model mem_u (.pins(pins), .q(q), .viol(viol));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(negedge pins.ras_n) begin
      if (pins.cas_n === 1'b0) refs_seen++;
   end

   // Ceiling well above init, scenarios and two refresh periods
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         test_done();
      end
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk_bits(input string what, input logic [3:0] exp,
         input logic [3:0] seen);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic chk_num(input string what, input int exp, input int seen);
      checks_done++;
      if (seen != exp) begin
         err_total++;
         $display("BAD %s expected %0d seen %0d", what, exp, seen);
      end
   endtask

   task automatic access(input ndc_op_t op, input logic [17:0] adr,
         input logic wd, output logic [3:0] data);
      int n;
      n = 0;
      data = 4'hx;
      @(posedge clk);
      req <= '{op, adr[17:9], adr[8:0], wd};
      req_valid <= 1'b1;
      @(negedge clk);
      while (req_ready !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
      req_valid <= 1'b0;
      n = 0;
      if (op != OP_WRITE) begin
         do begin
            @(negedge clk);
            n++;
         end while (resp.valid !== 1'b1 && n < 40);
         data = resp.data;
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_write_read();
      logic [3:0] d;
      access(OP_WRITE, 18'h3ffff, 1'b1, d);
      access(OP_WRITE, 18'h00000, 1'b0, d);
      access(OP_READ, 18'h3ffff, 1'b0, d);
      chk_bits("read after write one", 4'h1, d);
      access(OP_READ, 18'h00000, 1'b1, d);
      chk_bits("read after write zero", 4'h0, d);
   endtask

   task automatic t_rmw();
      logic [3:0] d;
      access(OP_RMW, 18'h3ffff, 1'b0, d);
      chk_bits("rmw old bit", 4'h1, d);
      access(OP_RMW, 18'h3ffff, 1'b1, d);
      chk_bits("rmw back to back", 4'h0, d);
      access(OP_READ, 18'h3ffff, 1'b0, d);
      chk_bits("read after rmw", 4'h1, d);
   endtask

   task automatic t_nibble();
      logic [3:0] p;
      logic [3:0] d;
      logic [3:0] e;
      logic [1:0] s;
      p = 4'hb;
      for (int k = 0; k < 4; k++) begin
         s = 2'(k);
         access(OP_WRITE, {s[1], 8'ha5, s[0], 8'h5a}, p[k], d);
      end
      for (int k = 0; k < 4; k++) begin
         s = 2'(k);
         for (int i = 0; i < 4; i++) e[i] = p[(k + i) % 4];
         access(OP_NIBBLE, {s[1], 8'ha5, s[0], 8'h5a}, 1'b0, d);
         chk_bits("nibble burst", e, d);
      end
   endtask

   // Enable held low mid access; row stays open longer, data must survive
   task automatic t_freeze();
      logic [3:0] d;
      fork
         access(OP_READ, 18'h3ffff, 1'b0, d);
         begin
            @(negedge req_valid);
            repeat (3) @(posedge clk);
            ce <= 1'b0;
            repeat (5) @(posedge clk);
            ce <= 1'b1;
         end
      join
      chk_bits("read across clock hold", 4'h1, d);
   endtask

   task automatic t_refresh();
      int r0;
      repeat (40) @(posedge clk);
      r0 = refs_seen;
      repeat (2 * C_REFI) @(posedge clk);
      chk_num("periodic refreshes", 2, refs_seen - r0);
   endtask

   initial begin
      int n;
      n = 0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      while (req_ready !== 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      chk_num("init refreshes", 8, refs_seen);
      t_write_read();
      t_rmw();
      t_nibble();
      t_freeze();
      t_refresh();
      chk_num("model timing faults", 0, viol);
      test_done();
   end
endmodule
